/* hw/nvm_pkg.sv */
// Package of register map, field layout and state types for the NVM command front end
package nvm_pkg;

	// Register offsets, byte addresses
	localparam logic [3:0] OFS_CLOCK_DIVIDER    = 4'h0;
	localparam logic [3:0] OFS_SECURITY         = 4'h1;
	localparam logic [3:0] OFS_COMMAND_INDEX    = 4'h2;
	localparam logic [3:0] OFS_RESERVED_ZERO    = 4'h3;
	localparam logic [3:0] OFS_CONFIGURATION    = 4'h4;
	localparam logic [3:0] OFS_ERROR_CONFIG     = 4'h5;
	localparam logic [3:0] OFS_COMMAND_STATUS   = 4'h6;
	localparam logic [3:0] OFS_ERROR_STATUS     = 4'h7;
	localparam logic [3:0] OFS_PFLASH_PROT      = 4'h8;
	localparam logic [3:0] OFS_EEPROM_PROT      = 4'h9;
	localparam logic [3:0] OFS_CMD_OBJ_HIGH     = 4'hA;
	localparam logic [3:0] OFS_CMD_OBJ_LOW      = 4'hB;
	localparam logic [3:0] OFS_RESERVED_ONE     = 4'hC;

	// Field positions
	localparam int BIT_PROTECT_OPEN  = 7;
	localparam int BIT_COMMAND_COMPLETE_FLAG          = 7;
	localparam int BIT_ACCERR        = 5;
	localparam int BIT_PROTECTION_VIOLATION_FLAG        = 4;
	localparam int BIT_MGBUSY        = 3;
	localparam int SIZE_MSB          = 4;
	localparam int INDEX_MSB         = 2;

	// Command object geometry
	localparam int          CMD_WORDS       = 6;
	localparam logic [2:0]  IDX_CMD_WORD    = 3'h0;
	localparam logic [2:0]  IDX_MARGIN_WORD = 3'h1;

	// Command codes
	localparam logic [7:0]  CMD_SET_MARGIN  = 8'h0E;
	localparam logic [7:0]  CMD_ERASE_EE    = 8'h12;
	localparam logic [7:0]  CMD_PROGRAM_EE  = 8'h11;
	localparam logic [7:0]  CMD_ERASE_SECT  = 8'h12;

	// Block select codes in low two bits of word 0
	localparam logic [1:0]  BLK_PFLASH      = 2'h0;
	localparam logic [1:0]  BLK_EEPROM      = 2'h1;

	// Margin settings
	localparam logic [15:0] MARGIN_NORMAL   = 16'h0000;
	localparam logic [15:0] MARGIN_MAX      = 16'h0004;

	// Reset values
	localparam logic [7:0]  RST_STATUS      = 8'h80;
	localparam logic [4:0]  SIZE_FULL       = 5'h1F;
	localparam logic [7:0]  READ_ZERO       = 8'h00;

	// Timing: time spent launching a command against the array, in ns
	localparam int EXEC_TIME_NS = 80;
	localparam int CLK_NS       = 8;
	localparam int EXEC_CYCLES  = (EXEC_TIME_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		ST_LOAD  = 4'h1,
		ST_IDLE  = 4'h2,
		ST_EXEC  = 4'h4,
		ST_DONE  = 4'h8
	} seq_state_t;

	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	// Array-side command
	typedef struct packed {
		logic        valid;
		logic [7:0]  code;
		logic [15:0] addr_hi;
		logic [15:0] addr_lo;
		logic [15:0] data;
	} array_cmd_t;

	// Margin levels applied to reads
	typedef struct packed {
		logic [2:0] pflash;
		logic [2:0] eeprom;
	} margin_t;

	// Whole module state
	typedef struct packed {
		seq_state_t  state;
		logic [7:0]  clock_div;
		logic [2:0]  index;
		logic [7:0]  config_r;
		logic [1:0]  err_cfg;
		logic        command_complete_flag;
		logic        accerr;
		logic        protection_violation_flag;
		logic        protect_open;
		logic [4:0]  protect_size;
		logic [95:0] cmd_obj;
		logic [3:0]  exec_cnt;
		margin_t     margin;
		logic [7:0]  rdata;
		logic        done;
	} nvm_state_t;

endpackage : nvm_pkg

/* hw/nvm_command_and_protection.sv */
// NVM command front end: register map, command object, EEPROM protection, margin command
// Summary of operation
// - EEPROM protection can only grow: size rises, open bit goes one to zero.
// - With the open bit set, the size field is ignored and nothing is protected.
// - Open bit at bit 7: zero protects, one leaves EEPROM unprotected.
// - Protected area size comes from the low five size bits.
// - Protection byte is loaded from the flash configuration byte after reset is released.
// - A double-bit fault on that load forces full EEPROM protection.
// - Program or erase of protected EEPROM is refused and sets the violation flag.
// - Whole EEPROM erase is refused while any sector is protected.
// - Command object is six 16-bit words behind index, high and low byte registers.
// - Either byte of the indexed word is readable and writable alone.
// - Command object stays locked from launch until the complete flag is set.
// - High byte of word zero is the command code.
// - Indices six and seven ignore writes and read as zero.
// - Margin command code 0x0E, special modes only, block code in low two bits.
// - Margin command applies word one's level to the target, then completes.
// - EEPROM target affects EEPROM reads; flash target affects both.
// - Margin codes zero to four valid, anything else is invalid.
// - Margin-1 biases toward erased state, margin-0 toward programmed state.
`timescale 1ns/1ps
`default_nettype none

module nvm_command_and_protection
	import nvm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire bus_req_t    bus_req,
	output logic [7:0]       rdata,
	input  wire logic        special_mode,
	input  wire logic [7:0]  cfg_protect_byte,
	input  wire logic        cfg_load_valid,
	input  wire logic        cfg_double_fault,
	output array_cmd_t       array_cmd,
	input  wire logic        array_done,
	output margin_t          read_margin,
	output logic             margin_bias_erased,
	output logic             margin_bias_programmed
);

	nvm_state_t s_r;
	nvm_state_t s_nxt;

	// Pin synchronisers for the mode strap and the array handshake
	logic [1:0] mode_sync_r;
	logic [1:0] done_sync_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mode_sync_r <= 2'h0;
			done_sync_r <= 2'h0;
		end
		else
		begin
			mode_sync_r <= {mode_sync_r[0], special_mode};
			done_sync_r <= {done_sync_r[0], array_done};
		end
	end

	// Decoded command fields
	logic [15:0] word0;
	logic [15:0] word1;
	logic [15:0] word_sel;
	logic        idx_valid;
	logic        protected_any;
	logic [5:0]  ee_sector;
	logic        hits_protected;

	always_comb
	begin
		word0     = s_r.cmd_obj[15:0];
		word1     = s_r.cmd_obj[31:16];
		idx_valid = (s_r.index < 3'(CMD_WORDS));
		word_sel  = 16'h0000;
		for (int i = 0; i < CMD_WORDS; i++)
		begin
			if (s_r.index == 3'(i))
			begin
				word_sel = s_r.cmd_obj[i*16 +: 16];
			end
		end
		// Open bit set means no sector protected, whatever the size says
		protected_any  = ~s_r.protect_open;
		// Sector number of the target from the upper address bits
		ee_sector      = s_r.cmd_obj[31:26];
		hits_protected = protected_any && ({1'b0, ee_sector[4:0]} <= {1'b0, s_r.protect_size});
	end

	// Next-state logic
	always_comb
	begin
		logic [7:0] wd;
		logic [4:0] new_size;
		wd       = bus_req.wdata;
		new_size = wd[SIZE_MSB:0];
		s_nxt    = s_r;
		s_nxt.done  = 1'b0;
		s_nxt.rdata = READ_ZERO;

		// Register reads, one cycle latency
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				OFS_CLOCK_DIVIDER:  s_nxt.rdata = s_r.clock_div;
				OFS_COMMAND_INDEX:  s_nxt.rdata = {5'h00, s_r.index};
				OFS_CONFIGURATION:  s_nxt.rdata = s_r.config_r;
				OFS_ERROR_CONFIG:   s_nxt.rdata = {6'h00, s_r.err_cfg};
				OFS_COMMAND_STATUS: s_nxt.rdata = {s_r.command_complete_flag, 1'b0, s_r.accerr, s_r.protection_violation_flag,
					(s_r.state == ST_EXEC), 3'h0};
				OFS_EEPROM_PROT:    s_nxt.rdata = {s_r.protect_open, 2'h0, s_r.protect_size};
				OFS_CMD_OBJ_HIGH:   s_nxt.rdata = word_sel[15:8];
				OFS_CMD_OBJ_LOW:    s_nxt.rdata = word_sel[7:0];
				default:            s_nxt.rdata = READ_ZERO;
			endcase
		end

		case (s_r.state)
			// Reset load of protection byte from the configuration field
			ST_LOAD:
			begin
				if (cfg_load_valid)
				begin
					if (cfg_double_fault)
					begin
						s_nxt.protect_open = 1'b0;
						s_nxt.protect_size = SIZE_FULL;
					end
					else
					begin
						s_nxt.protect_open = cfg_protect_byte[BIT_PROTECT_OPEN];
						s_nxt.protect_size = cfg_protect_byte[SIZE_MSB:0];
					end
					s_nxt.state = ST_IDLE;
				end
			end
			ST_IDLE:
			begin
				if (bus_req.wr)
				begin
					case (bus_req.addr)
						OFS_CLOCK_DIVIDER: s_nxt.clock_div = wd;
						OFS_COMMAND_INDEX: s_nxt.index = wd[INDEX_MSB:0];
						OFS_CONFIGURATION: s_nxt.config_r = wd;
						OFS_ERROR_CONFIG:  s_nxt.err_cfg = wd[1:0];
						OFS_EEPROM_PROT:
						begin
							// Only growth is accepted; shrinking fields hold
							if (new_size > s_r.protect_size)
							begin
								s_nxt.protect_size = new_size;
							end
							if (!wd[BIT_PROTECT_OPEN])
							begin
								s_nxt.protect_open = 1'b0;
							end
						end
						OFS_CMD_OBJ_HIGH:
						begin
							if (idx_valid)
							begin
								s_nxt.cmd_obj[s_r.index*16 + 8 +: 8] = wd;
							end
						end
						OFS_CMD_OBJ_LOW:
						begin
							if (idx_valid)
							begin
								s_nxt.cmd_obj[s_r.index*16 +: 8] = wd;
							end
						end
						OFS_COMMAND_STATUS:
						begin
							// Error flags are write-one-to-clear
							if (wd[BIT_ACCERR])
							begin
								s_nxt.accerr = 1'b0;
							end
							if (wd[BIT_PROTECTION_VIOLATION_FLAG])
							begin
								s_nxt.protection_violation_flag = 1'b0;
							end
							// Launch only with clean error flags
							if (wd[BIT_COMMAND_COMPLETE_FLAG] && !s_r.accerr && !s_r.protection_violation_flag)
							begin
								s_nxt.command_complete_flag     = 1'b0;
								s_nxt.exec_cnt = 4'h0;
								s_nxt.state    = ST_EXEC;
							end
						end
						default: ;
					endcase
				end
			end
			// Command running: object locked, only index writes taken
			ST_EXEC:
			begin
				if (bus_req.wr && bus_req.addr == OFS_COMMAND_INDEX)
				begin
					s_nxt.index = wd[INDEX_MSB:0];
				end
				// Saturate so a slow array cannot wrap the minimum-time count
				if (s_r.exec_cnt < 4'(EXEC_CYCLES))
				begin
					s_nxt.exec_cnt = s_r.exec_cnt + 4'h1;
				end
				case (word0[15:8])
					CMD_SET_MARGIN:
					begin
						if (!mode_sync_r[1] || word1 > MARGIN_MAX)
						begin
							s_nxt.accerr = 1'b1;
						end
						else if (word0[1:0] == BLK_EEPROM)
						begin
							s_nxt.margin.eeprom = word1[2:0];
						end
						else if (word0[1:0] == BLK_PFLASH)
						begin
							s_nxt.margin.pflash = word1[2:0];
							s_nxt.margin.eeprom = word1[2:0];
						end
						else
						begin
							s_nxt.accerr = 1'b1;
						end
						s_nxt.state = ST_DONE;
					end
					CMD_PROGRAM_EE, CMD_ERASE_EE:
					begin
						if (hits_protected || (word0[15:8] == CMD_ERASE_EE && protected_any))
						begin
							s_nxt.protection_violation_flag = 1'b1;
							s_nxt.state  = ST_DONE;
						end
						else if (done_sync_r[1] && s_r.exec_cnt >= 4'(EXEC_CYCLES))
						begin
							s_nxt.state = ST_DONE;
						end
					end
					default:
					begin
						if (done_sync_r[1] && s_r.exec_cnt >= 4'(EXEC_CYCLES))
						begin
							s_nxt.state = ST_DONE;
						end
					end
				endcase
			end
			ST_DONE:
			begin
				s_nxt.command_complete_flag  = 1'b1;
				s_nxt.done  = 1'b1;
				s_nxt.state = ST_IDLE;
			end
			default: s_nxt.state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_r              <= '0;
			s_r.state        <= ST_LOAD;
			s_r.command_complete_flag         <= RST_STATUS[BIT_COMMAND_COMPLETE_FLAG];
			s_r.protect_size <= SIZE_FULL;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// Outputs from flip-flops
	always_comb
	begin
		rdata                  = s_r.rdata;
		// A refused command never reaches the array, not even for its first cycle
		array_cmd.valid        = (s_r.state == ST_EXEC) && (word0[15:8] != CMD_SET_MARGIN) && !s_r.protection_violation_flag
			&& !hits_protected && !((word0[15:8] == CMD_ERASE_EE) && protected_any);
		array_cmd.code         = word0[15:8];
		array_cmd.addr_hi      = word0;
		array_cmd.addr_lo      = word1;
		array_cmd.data         = s_r.cmd_obj[47:32];
		read_margin            = s_r.margin;
		// Odd codes are margin-1 (erased bias), even non-zero codes margin-0
		margin_bias_erased     = s_r.margin.eeprom[0];
		margin_bias_programmed = (s_r.margin.eeprom != 3'h0) && !s_r.margin.eeprom[0];
	end

endmodule : nvm_command_and_protection

`default_nettype wire

/* dv/nvm_array_model.sv */
// Behavioural model of the flash and EEPROM arrays behind the command port
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model
	import nvm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire array_cmd_t array_cmd,
	input  wire logic       slow,
	output logic            array_done
);
	logic [5:0] busy_r;

	// Count array time; done only while the command is still presented
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busy_r <= 6'h00;
		else
			busy_r <= array_cmd.valid ? busy_r + 6'h01 : 6'h00;
	end
	assign array_done = array_cmd.valid && (busy_r >= (slow ? 6'h28 : 6'h03));
endmodule : nvm_array_model
`default_nettype wire

/* dv/nvm_cmd_checker.sv */
// Port-level assertions for the NVM command front end
`timescale 1ns/1ps
`default_nettype none
module nvm_cmd_checker
	import nvm_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire bus_req_t   bus_req,
	input wire logic [7:0] rdata,
	input wire logic       special_mode,
	input wire array_cmd_t array_cmd,
	input wire margin_t    read_margin,
	input wire logic       margin_bias_erased,
	input wire logic       margin_bias_programmed
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Read data only in the cycle after a read strobe
	AST_RD_IDLE: assert property (!bus_req.rd |=> rdata == 8'h00) else $error("read data outside slot");
	AST_MARGIN_RANGE: assert property (read_margin.pflash <= 3'h4 && read_margin.eeprom <= 3'h4)
		else $error("margin level out of range");
	AST_BIAS_ERASED: assert property (margin_bias_erased == (read_margin.eeprom inside {3'h1, 3'h3}))
		else $error("erased bias wrong");
	AST_BIAS_PROG: assert property (margin_bias_programmed == (read_margin.eeprom inside {3'h2, 3'h4}))
		else $error("programmed bias wrong");
	AST_CODE: assert property (array_cmd.valid |-> array_cmd.code == array_cmd.addr_hi[15:8]
		&& array_cmd.code != CMD_SET_MARGIN) else $error("command code not word zero high");
	// Object writes during execution must not reach the array fields
	AST_LOCK: assert property (array_cmd.valid && bus_req.wr |=>
		$stable({array_cmd.addr_hi, array_cmd.addr_lo, array_cmd.data})) else $error("object not locked");
	AST_EXEC_MIN: assert property ($rose(array_cmd.valid) |=> array_cmd.valid[*8])
		else $error("array command cut short");
	AST_SPECIAL: assert property ((!special_mode)[*8] |=> $stable(read_margin))
		else $error("margin changed outside special mode");
	cover property ($rose(array_cmd.valid));
	cover property ($rose(margin_bias_erased));
	cover property ($rose(margin_bias_programmed));
endmodule : nvm_cmd_checker
bind nvm_command_and_protection nvm_cmd_checker chk_u (.*);
`default_nettype wire

/* dv/tb_nvm_command_and_protection.sv */
// Self-checking bench for the NVM command front end
`timescale 1ns/1ps
`default_nettype none
module tb_nvm_command_and_protection
	import nvm_pkg::*;
;
	logic       clk = 1'b0, rst = 1'b1, spec = 1'b1, ldv = 1'b1, dflt = 1'b0, slow = 1'b1;
	logic       done, seen, be, bp;
	logic [7:0] cfg = 8'h85, rdata, st;
	bus_req_t   bus = '0;
	array_cmd_t acmd;
	margin_t    mg;
	int         n_errors = 0, compares = 0;

	always #4 clk = ~clk;
	// Note whether a command ever reached the array
	always @(posedge clk)
		if (acmd.valid === 1'b1)
			seen <= 1'b1;

	nvm_command_and_protection dut_u (.clk(clk), .rst(rst), .bus_req(bus), .rdata(rdata), .special_mode(spec),
		.cfg_protect_byte(cfg), .cfg_load_valid(ldv), .cfg_double_fault(dflt), .array_cmd(acmd),
		.array_done(done), .read_margin(mg), .margin_bias_erased(be), .margin_bias_programmed(bp));
	nvm_array_model arr_u (.clk(clk), .rst(rst), .array_cmd(acmd), .slow(slow), .array_done(done));

	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bus cycles start just after a rising edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask : rc

	// Load words 0 and 1, launch, try a locked write, poll for completion
	task automatic cmd(input logic [7:0] code, input logic [7:0] lo0, input logic [15:0] w1);
		int i;
		wr(OFS_COMMAND_INDEX, 8'h00);
		wr(OFS_CMD_OBJ_HIGH, code);
		wr(OFS_CMD_OBJ_LOW, lo0);
		wr(OFS_COMMAND_INDEX, 8'h01);
		wr(OFS_CMD_OBJ_HIGH, w1[15:8]);
		wr(OFS_CMD_OBJ_LOW, w1[7:0]);
		seen = 1'b0;
		wr(OFS_COMMAND_STATUS, 8'h80);
		wr(OFS_CMD_OBJ_HIGH, 8'h5A);
		for (i = 0; i < 200; i++)
		begin
			bus <= '{OFS_COMMAND_STATUS, 8'h00, 1'b0, 1'b1};
			@(posedge clk);
			bus.rd <= 1'b0;
			#1 st = rdata;
			@(posedge clk);
			if (st[7] === 1'b1)
				break;
		end
		if (i == 200)
		begin
			n_errors++;
			close_out();
		end
		rc(OFS_CMD_OBJ_HIGH, w1[15:8]);
	endtask : cmd

	task automatic t_exec;
		cmd(CMD_PROGRAM_EE, 8'h00, 16'h0000);
		chk(st, 8'h80);
		chk({7'h00, seen}, 8'h01);
		slow <= 1'b0;
		cmd(CMD_PROGRAM_EE, 8'h00, 16'h0400);
		chk({7'h00, seen}, 8'h01);
	endtask : t_exec

	task automatic t_prot;
		rc(OFS_EEPROM_PROT, 8'h85);
		wr(OFS_EEPROM_PROT, 8'h83);
		rc(OFS_EEPROM_PROT, 8'h85);
		wr(OFS_EEPROM_PROT, 8'h07);
		rc(OFS_EEPROM_PROT, 8'h07);
		wr(OFS_EEPROM_PROT, 8'h80);
		rc(OFS_EEPROM_PROT, 8'h07);
	endtask : t_prot

	// Sector 1 lies inside size 7; a whole erase meets protection anywhere
	task automatic t_viol;
		cmd(CMD_PROGRAM_EE, 8'h00, 16'h0400);
		chk(st, 8'h90);
		chk({7'h00, seen}, 8'h00);
		wr(OFS_COMMAND_STATUS, 8'h30);
		cmd(CMD_ERASE_EE, 8'h00, 16'hFC00);
		chk({7'h00, seen}, 8'h00);
		wr(OFS_COMMAND_STATUS, 8'h30);
	endtask : t_viol

	task automatic t_margin;
		logic [7:0] bl [6] = '{8'h01, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
		logic [7:0] lv [6] = '{8'h03, 8'h02, 8'h01, 8'h05, 8'h04, 8'h00};
		logic [7:0] ex [6] = '{8'h03, 8'h22, 8'h21, 8'h21, 8'h44, 8'h00};
		for (int k = 0; k < 6; k++)
		begin
			cmd(CMD_SET_MARGIN, bl[k], {8'h00, lv[k]});
			chk(st, (lv[k] == 8'h05) ? 8'hA0 : 8'h80);
			chk({1'b0, mg.pflash, 1'b0, mg.eeprom}, ex[k]);
			wr(OFS_COMMAND_STATUS, 8'h20);
		end
		spec <= 1'b0;
		repeat (4) @(posedge clk);
		cmd(CMD_SET_MARGIN, 8'h01, 16'h0003);
		chk(st, 8'hA0);
		chk({1'b0, mg.pflash, 1'b0, mg.eeprom}, 8'h00);
	endtask : t_margin

	// Second reset with a faulty configuration read
	task automatic t_fault;
		dflt <= 1'b1;
		cfg <= 8'h80;
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(OFS_EEPROM_PROT, 8'h1F);
	endtask : t_fault

	task automatic t_idx;
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_COMMAND_INDEX, i[7:0]);
			wr(OFS_CMD_OBJ_HIGH, 8'hC0 + i[7:0]);
			wr(OFS_CMD_OBJ_LOW, 8'h30 + i[7:0]);
		end
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_COMMAND_INDEX, i[7:0]);
			rc(OFS_CMD_OBJ_HIGH, (i < 6) ? 8'hC0 + i[7:0] : 8'h00);
			rc(OFS_CMD_OBJ_LOW, (i < 6) ? 8'h30 + i[7:0] : 8'h00);
		end
		rc(4'hD, 8'h00);
	endtask : t_idx

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_exec();
		t_prot();
		t_viol();
		t_margin();
		t_fault();
		t_idx();
		close_out();
	end
endmodule : tb_nvm_command_and_protection
`default_nettype wire
